//--- hw/port_regs_pkg.sv
/*
  Constants, field layout and state record of the configure-flag and
  first port control/status register bank.
  Assumes a 25 MHz pclk and an APB slave placed in a 4 KB window.
*/
// Contract
// - Setup-done register: only bit 0 is used, rest reserved, resets zero.
// - Setup-done flag drives default port routing (own versus companion).
// - Port register resets only on power-up or host-controller reset.
// - After reset the port shows nothing attached and disabled.
// - With power control, port state writes ignored until power bit set.
// - Port fields at documented positions; hand-off flag resets to one.
// - Hand-off clears on setup-done rising, forced one while it is zero.
// - Attach-change sets whenever attach-present changes, else reads zero; the code keeps it set until a write of one, power off or reset clears it.
// - With power off, reset/sleep/resume/enable/attach fields read zero.
package port_regs_pkg;

  // Byte offsets inside the slave window
  localparam logic [11:0] SETUP_DONE_OFS = 12'h060;
  localparam logic [11:0] PORT_OFS       = 12'h064;
  localparam logic [11:0] IRQ_STS_OFS    = 12'h068;
  localparam logic [11:0] IRQ_MSK_OFS    = 12'h06c;

  // Field positions
  localparam int SDF_BIT     = 0;
  localparam int TMODE_LSB   = 16;
  localparam int IND_LSB     = 14;
  localparam int HANDOFF_BIT = 13;
  localparam int PWR_BIT     = 12;
  localparam int LINE_LSB    = 10;
  localparam int BRST_BIT    = 8;
  localparam int SLEEP_BIT   = 7;
  localparam int RESUME_BIT  = 6;
  localparam int ENA_BIT     = 2;
  localparam int CHG_BIT     = 1;
  localparam int PRES_BIT    = 0;
  localparam int EV_CHG_BIT  = 0;
  localparam int EV_PWR_BIT  = 1;

  // Values after reset
  localparam logic       SDF_RST     = 1'b0;
  localparam logic       HANDOFF_RST = 1'b1;
  localparam logic [3:0] TMODE_RST   = 4'h0;
  localparam logic [1:0] IND_RST     = 2'h0;
  localparam logic [1:0] IRQ_RST     = 2'h0;

  // Port capabilities
  localparam logic PORT_POWER_CTRL = 1'b1;
  localparam logic INDICATOR_CAP   = 1'b0;

  // Power settle time and its cycle count
  localparam int PWR_STABLE_MS  = 20;
  localparam int CLK_KHZ        = 25000;
  localparam int PWR_STABLE_CYC = PWR_STABLE_MS * CLK_KHZ;

  // Whole state of the bank
  typedef struct packed {
    logic        att_s1;
    logic        att_s2;
    logic        dp_s1;
    logic        dp_s2;
    logic        dm_s1;
    logic        dm_s2;
    logic        setup_done;
    logic        handoff;
    logic        power;
    logic [3:0]  tmode;
    logic [1:0]  ind;
    logic        breset;
    logic        sleep;
    logic        resume;
    logic        enable;
    logic        chg;
    logic        pres_q;
    logic [19:0] pwr_cnt;
    logic [1:0]  irq_sts;
    logic [1:0]  irq_msk;
    logic [31:0] prdata;
  } state_t;

endpackage

//--- hw/host_port_config_status_regs.sv
/*
  APB register bank holding the setup-done flag and the control/status
  word of downstream port 1, with attach tracking, power settle timing
  and a maskable interrupt.
  Assumes presetn is the power-up reset of the auxiliary well, hc_reset
  a one-cycle-or-longer synchronous pulse from pclk logic, and the line
  and attach inputs asynchronous pins.
  Software is expected to wait for the power-stable event before it
  touches port state; the bank drops state writes only until the power bit is set.
*/
`timescale 1ns/1ps
module host_port_config_status_regs #(
  parameter int PWR_WAIT_CYC = port_regs_pkg::PWR_STABLE_CYC
) (
  // Clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        hc_reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Port pins
  input  wire logic        attach_in,
  input  wire logic        line_dp_in,
  input  wire logic        line_dm_in,
  // Port controls
  output logic             companion_owns,
  output logic             port_power_on,
  output logic             port_enabled,
  output logic             bus_reset_drive,
  output logic             sleep_state,
  output logic             resume_drive,
  output logic [3:0]       test_mode_select,
  output logic [1:0]       indicator_lamp_ctrl,
  // Interrupt
  output logic             irq
);

  port_regs_pkg::state_t r;
  port_regs_pkg::state_t n;

  logic [31:0] port_word;
  logic [31:0] cfg_word;
  logic [31:0] rd_word;
  logic [31:0] byte_mask;
  logic [31:0] port_wr;
  logic [31:0] cfg_wr;
  logic [31:0] msk_wr;
  logic        acc_wr;
  logic        acc_rd;
  logic        setup_rd;
  logic        hit;
  logic        sel_cfg;
  logic        sel_port;
  logic        sel_sts;
  logic        sel_msk;
  logic        present;
  logic        may_change;
  logic        ev_chg;
  logic        ev_pwr;

  // Address decode and phase qualifiers
  assign sel_cfg  = (paddr == port_regs_pkg::SETUP_DONE_OFS);
  assign sel_port = (paddr == port_regs_pkg::PORT_OFS);
  assign sel_sts  = (paddr == port_regs_pkg::IRQ_STS_OFS);
  assign sel_msk  = (paddr == port_regs_pkg::IRQ_MSK_OFS);
  assign hit      = sel_cfg | sel_port | sel_sts | sel_msk;
  assign acc_wr   = psel & penable & pwrite & hit;
  assign acc_rd   = psel & penable & ~pwrite & hit;
  assign setup_rd = psel & ~penable & ~pwrite;

  // Zero-wait slave; unmapped addresses answer with an error
  // Trade-off: no wait states keeps the master simple, at the cost of
  // latching read data one edge early, in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = r.prdata;

  // Byte lanes that a write may touch
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                      {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Attach seen only while the port is powered
  assign present = r.att_s2 & r.power;

  // Without power control the port state is always writable
  assign may_change = r.power | ~port_regs_pkg::PORT_POWER_CTRL;

  // Setup-done word: one live bit, reserved bits read zero
  always_comb
  begin
    cfg_word = 32'h0000_0000;
    cfg_word[port_regs_pkg::SDF_BIT] = r.setup_done;
  end

  // Port word as software sees it
  always_comb
  begin
    port_word = 32'h0000_0000;
    port_word[port_regs_pkg::TMODE_LSB +: 4] = r.tmode;
    port_word[port_regs_pkg::IND_LSB +: 2]   = r.ind;
    port_word[port_regs_pkg::HANDOFF_BIT]    = r.handoff;
    port_word[port_regs_pkg::PWR_BIT]        = r.power;
    port_word[port_regs_pkg::LINE_LSB + 1]   = r.dp_s2;
    port_word[port_regs_pkg::LINE_LSB]       = r.dm_s2;
    // Power-dependent fields are masked on read as well
    if (r.power)
    begin
      port_word[port_regs_pkg::BRST_BIT]   = r.breset;
      port_word[port_regs_pkg::SLEEP_BIT]  = r.sleep;
      port_word[port_regs_pkg::RESUME_BIT] = r.resume;
      port_word[port_regs_pkg::ENA_BIT]    = r.enable;
      port_word[port_regs_pkg::CHG_BIT]    = r.chg;
      port_word[port_regs_pkg::PRES_BIT]   = r.pres_q;
    end
  end

  // Read multiplexer
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (sel_cfg)
    begin
      rd_word = cfg_word;
    end
    else if (sel_port)
    begin
      rd_word = port_word;
    end
    else if (sel_sts)
    begin
      rd_word[1:0] = r.irq_sts;
    end
    else if (sel_msk)
    begin
      rd_word[1:0] = r.irq_msk;
    end
  end

  // Merge write data into current contents per byte lane
  assign cfg_wr  = (cfg_word & ~byte_mask) | (pwdata & byte_mask);
  assign port_wr = (port_word & ~byte_mask) | (pwdata & byte_mask);
  assign msk_wr  = ({30'h0, r.irq_msk} & ~byte_mask)
                 | (pwdata & byte_mask);

  // Events seen this cycle
  assign ev_chg = (present != r.pres_q);
  assign ev_pwr = (r.pwr_cnt == 20'h0_0001);

  // Next state of the whole bank
  always_comb
  begin
    n = r;

    // Two-stage synchronisers; stage one feeds stage two only
    // Pins change with no regard to pclk, so nothing reads stage one
    n.att_s1 = attach_in;
    n.att_s2 = r.att_s1;
    n.dp_s1  = line_dp_in;
    n.dp_s2  = r.dp_s1;
    n.dm_s1  = line_dm_in;
    n.dm_s2  = r.dm_s1;

    // Read data is latched in the setup phase
    // so that the access cycle shows a settled word; it then stands
    // until the next read setup cycle
    if (setup_rd)
    begin
      n.prdata = rd_word;
    end

    // Port word write
    if (acc_wr && sel_port)
    begin
      if (port_regs_pkg::PORT_POWER_CTRL)
      begin
        n.power = port_wr[port_regs_pkg::PWR_BIT];
      end
      // Ownership is meaningful only once configured
      if (r.setup_done)
      begin
        n.handoff = port_wr[port_regs_pkg::HANDOFF_BIT];
      end
      // State writes are dropped until the port is powered
      if (may_change)
      begin
        n.tmode  = port_wr[port_regs_pkg::TMODE_LSB +: 4];
        n.breset = port_wr[port_regs_pkg::BRST_BIT];
        n.sleep  = port_wr[port_regs_pkg::SLEEP_BIT];
        n.resume = port_wr[port_regs_pkg::RESUME_BIT];
        n.enable = port_wr[port_regs_pkg::ENA_BIT];
        if (port_regs_pkg::INDICATOR_CAP)
        begin
          n.ind = port_wr[port_regs_pkg::IND_LSB +: 2];
        end
        // Write one clears, zero leaves alone
        if (port_wr[port_regs_pkg::CHG_BIT])
        begin
          n.chg = 1'b0;
        end
      end
    end

    // Setup-done write; a rising flag takes the port over
    if (acc_wr && sel_cfg)
    begin
      n.setup_done = cfg_wr[port_regs_pkg::SDF_BIT];
      if (!r.setup_done && cfg_wr[port_regs_pkg::SDF_BIT])
      begin
        n.handoff = 1'b0;
      end
    end

    // Unconfigured controller leaves the port to the companion
    if (!n.setup_done)
    begin
      n.handoff = 1'b1;
    end

    // Attach tracking; a change beats a same-cycle clear
    // A lost peripheral cannot stay enabled, so enable follows attach
    // down but never up
    n.pres_q = present;
    if (ev_chg)
    begin
      n.chg = 1'b1;
    end
    if (!present)
    begin
      n.enable = 1'b0;
    end

    // Power settle timer, reloaded on each power-on edge
    // The event fires once, PWR_WAIT_CYC edges after power rises;
    // turning power off mid-count abandons the wait
    if (n.power && !r.power)
    begin
      n.pwr_cnt = 20'(PWR_WAIT_CYC);
    end
    else if (!n.power)
    begin
      n.pwr_cnt = 20'h0_0000;
    end
    else if (r.pwr_cnt != 20'h0_0000)
    begin
      n.pwr_cnt = r.pwr_cnt - 20'h0_0001;
    end

    // Unpowered port holds no reset, sleep, resume, enable or change state
    if (!n.power)
    begin
      n.breset = 1'b0;
      n.sleep  = 1'b0;
      n.resume = 1'b0;
      n.enable = 1'b0;
      n.chg    = 1'b0;
    end

    // Interrupt mask and read-to-clear status
    if (acc_wr && sel_msk)
    begin
      n.irq_msk = msk_wr[1:0];
    end
    // Clear only what the setup cycle reported, so an event that lands
    // on the setup edge survives the read
    if (acc_rd && sel_sts)
    begin
      n.irq_sts = r.irq_sts & ~r.prdata[1:0];
    end
    // Events set after the clear so none is lost
    if (ev_chg)
    begin
      n.irq_sts[port_regs_pkg::EV_CHG_BIT] = 1'b1;
    end
    if (ev_pwr)
    begin
      n.irq_sts[port_regs_pkg::EV_PWR_BIT] = 1'b1;
    end

    // Controller reset: the only reset besides power-up
    // Mask and synchronisers are kept so a pin level is not lost
    if (hc_reset)
    begin
      n.setup_done = port_regs_pkg::SDF_RST;
      n.handoff    = port_regs_pkg::HANDOFF_RST;
      n.power      = ~port_regs_pkg::PORT_POWER_CTRL;
      n.tmode      = port_regs_pkg::TMODE_RST;
      n.ind        = port_regs_pkg::IND_RST;
      n.breset     = 1'b0;
      n.sleep      = 1'b0;
      n.resume     = 1'b0;
      n.enable     = 1'b0;
      n.chg        = 1'b0;
      n.pres_q     = 1'b0;
      n.pwr_cnt    = 20'h0_0000;
      n.irq_sts    = port_regs_pkg::IRQ_RST;
    end
  end

  // State register; power-up reset of the auxiliary well
  // Reset branch loads constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r            <= '0;
      r.setup_done <= port_regs_pkg::SDF_RST;
      r.handoff    <= port_regs_pkg::HANDOFF_RST;
      r.power      <= ~port_regs_pkg::PORT_POWER_CTRL;
      r.tmode      <= port_regs_pkg::TMODE_RST;
      r.ind        <= port_regs_pkg::IND_RST;
      r.enable     <= 1'b0;
      r.pres_q     <= 1'b0;
      r.irq_sts    <= port_regs_pkg::IRQ_RST;
      r.irq_msk    <= port_regs_pkg::IRQ_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // Routing and port controls straight from the register
  assign companion_owns      = r.handoff;
  assign port_power_on       = r.power;
  assign port_enabled        = r.enable;
  assign bus_reset_drive     = r.breset;
  assign sleep_state         = r.sleep;
  assign resume_drive        = r.resume;
  assign test_mode_select    = r.tmode;
  assign indicator_lamp_ctrl = r.ind;

  // Level interrupt, high while an unmasked event is pending
  // Driven from registers only, so it carries no glitches
  assign irq = |(r.irq_sts & r.irq_msk);

endmodule

//--- testbench/port_checks_asserts.sv
/*
  Concurrent checks on the port register bank, bound to its top module.
  Assumes one pclk domain and presetn as its asynchronous reset.
*/
`timescale 1ns/1ps
module port_checks_asserts (
  // Clock and resets
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        hc_reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  // Port controls and interrupt
  input wire logic        companion_owns,
  input wire logic        port_power_on,
  input wire logic        port_enabled,
  input wire logic        bus_reset_drive,
  input wire logic        sleep_state,
  input wire logic        resume_drive,
  input wire logic [3:0]  test_mode_select,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sdf_q;
  wire  wr_sdf = psel && penable && pwrite && paddr == 12'h060;
  wire  rd_sdf = psel && penable && !pwrite && paddr == 12'h060;
  // Shadow of the setup flag, since the flag itself has no pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sdf_q <= 1'b0;
    else if (hc_reset)
      sdf_q <= 1'b0;
    else if (wr_sdf && pstrb[0])
      sdf_q <= pwdata[0];
  end
  // Setup edge loads read data, access cycle shows it
  sequence port_rd_s;
    psel && !penable && !pwrite && paddr == 12'h064 && !hc_reset
    ##1 psel && penable;
  endsequence
  sdf_rsvd_a: assert property (rd_sdf |-> prdata[31:1] == 31'h0)
    else $error("setup register reserved bits not zero");
  port_rsvd_a: assert property (port_rd_s
    |-> prdata[31:20] == 12'h0
    && prdata[15:14] == 2'h0 && !prdata[9] && prdata[5:3] == 3'h0)
    else $error("port word reserved bits not zero");
  port_fields_a: assert property (port_rd_s |->
    {prdata[19:16], prdata[13:12], prdata[8:6]} == {test_mode_select,
    companion_owns, port_power_on, bus_reset_drive, sleep_state,
    resume_drive}) else $error("port word field out of place");
  handoff_force_a: assert property (!sdf_q && !$past(sdf_q)
    |-> companion_owns) else $error("hand-off low while flag clear");
  handoff_clr_a: assert property (wr_sdf && pstrb[0] && pwdata[0]
    && !sdf_q && !hc_reset |=> !companion_owns)
    else $error("hand-off kept on flag rise");
  pwr_off_a: assert property (!port_power_on
    && !$past(port_power_on)
    |-> !(port_enabled || bus_reset_drive || sleep_state || resume_drive))
    else $error("port state active without power");
  en_pwr_a: assert property ($rose(port_enabled) |-> port_power_on)
    else $error("port enabled without power");
  hc_clear_a: assert property (hc_reset |=> companion_owns && !irq
    && !port_power_on && !port_enabled && test_mode_select == 4'h0)
    else $error("controller reset left port state");
endmodule

bind host_port_config_status_regs port_checks_asserts u_port_checks_asserts (
  .pclk(pclk), .presetn(presetn), .hc_reset(hc_reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .companion_owns(companion_owns),
  .port_power_on(port_power_on), .port_enabled(port_enabled),
  .bus_reset_drive(bus_reset_drive), .sleep_state(sleep_state),
  .resume_drive(resume_drive), .test_mode_select(test_mode_select),
  .irq(irq));

//--- testbench/usb_peripheral_model.sv
/*
  Peripheral on downstream port 1: attach pin and line levels.
  Assumes host-side pull-downs, so a detached port shows both lines low.
*/
`timescale 1ns/1ps
module usb_peripheral_model (
  // Control from the bench
  input  wire logic pclk,
  input  wire logic plugged,
  // Port pins
  output logic      attach_in,
  output logic      line_dp_in,
  output logic      line_dm_in
);
  initial {attach_in, line_dp_in, line_dm_in} = 3'h0;
  // Attached device idles in J, data plus high
  always @(posedge pclk)
  begin
    attach_in  <= plugged;
    line_dp_in <= plugged;
    line_dm_in <= 1'b0;
  end
endmodule

//--- testbench/host_port_config_status_regs_bench.sv
/*
  Self-checking bench for the port register bank over APB.
  Assumes a short power settle parameter and the peripheral model.
*/
`timescale 1ns/1ps
`define CHK(s, x, g) begin check_count++; if ((g) !== (x)) begin \
  $display("Error %s exp %h got %h", s, x, g); err_count++; end end
module host_port_config_status_regs_bench;
  logic        pclk = 1'b0, presetn = 1'b0, hc_reset = 1'b0, plugged = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0]  pstrb = 4'hf, test_mode_select;
  logic [1:0]  indicator_lamp_ctrl;
  logic        pready, pslverr, attach_in, line_dp_in, line_dm_in, e, irq;
  logic        companion_owns, port_power_on, port_enabled;
  logic        bus_reset_drive, sleep_state, resume_drive;
  wire  [2:0]  drv = {bus_reset_drive, sleep_state, resume_drive};
  int          err_count = 0, check_count = 0, cyc = 0;
  host_port_config_status_regs #(.PWR_WAIT_CYC(16))
    u_host_port_config_status_regs (
    .pclk(pclk), .presetn(presetn), .hc_reset(hc_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .attach_in(attach_in), .line_dp_in(line_dp_in),
    .line_dm_in(line_dm_in), .companion_owns(companion_owns),
    .port_power_on(port_power_on), .port_enabled(port_enabled),
    .bus_reset_drive(bus_reset_drive), .sleep_state(sleep_state),
    .resume_drive(resume_drive), .test_mode_select(test_mode_select),
    .indicator_lamp_ctrl(indicator_lamp_ctrl), .irq(irq));
  usb_peripheral_model u_usb_peripheral_model (.pclk(pclk),
    .plugged(plugged), .attach_in(attach_in), .line_dp_in(line_dp_in),
    .line_dm_in(line_dm_in));
  always #20 pclk = ~pclk;
  // Cycle ceiling guards against a hung handshake
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer; request held until pready seen at an edge
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave; only the bench ceiling ends a hang
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, string s);
    apb(a, 1'b0, 32'h0);
    `CHK(s, x, q)
  endtask
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 40) begin @(negedge pclk); n++; end
    `CHK("irq", v, irq)
  endtask
  task automatic t_reset();
    rd(12'h060, 32'h0, "setup");
    rd(12'h064, 32'h00002000, "port");
    rd(12'h06c, 32'h0, "mask");
    `CHK("owner", 1'b1, companion_owns)
    $display("reset values done");
  endtask
  // Port state writes are refused while unpowered, hand-off writes while unconfigured
  task automatic t_refuse();
    wr(12'h064, 32'h000001c4);
    rd(12'h064, 32'h00002000, "unpowered");
    apb(12'h070, 1'b0, 32'h0);
    `CHK("slverr", 1'b1, e)
    `CHK("bad read", 32'h0, q)
    $display("refusals done");
  endtask
  task automatic t_setup();
    wr(12'h060, 32'h1);
    @(negedge pclk) `CHK("owner", 1'b0, companion_owns)
    rd(12'h060, 32'h1, "setup");
    wr(12'h060, 32'h0);
    @(negedge pclk) `CHK("owner", 1'b1, companion_owns)
    wr(12'h060, 32'h1);
    @(negedge pclk) `CHK("owner", 1'b0, companion_owns)
    $display("setup flag done");
  endtask
  task automatic t_power();
    wr(12'h06c, 32'h3);
    wr(12'h064, 32'h00001000);
    // Settle event is due 16 edges after the power write lands
    repeat (15) @(posedge pclk);
    @(negedge pclk) `CHK("early irq", 1'b0, irq)
    wait_irq(1'b1);
    rd(12'h068, 32'h2, "power event");
    rd(12'h068, 32'h0, "read clear");
    @(posedge pclk) plugged <= 1'b1;
    wait_irq(1'b1);
    rd(12'h064, 32'h00001803, "attach");
    wr(12'h064, 32'h00001004);
    rd(12'h064, 32'h00001807, "chg kept");
    wr(12'h064, 32'h0005d006);
    rd(12'h064, 32'h00051805, "chg clear");
    `CHK("tmode", 4'h5, test_mode_select)
    `CHK("lamp", 2'h0, indicator_lamp_ctrl)
    rd(12'h068, 32'h1, "attach event");
    wr(12'h06c, 32'h0);
    @(posedge pclk) plugged <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK("masked", 1'b0, irq)
    rd(12'h064, 32'h00051002, "detach");
    wr(12'h06c, 32'h1);
    wait_irq(1'b1);
    rd(12'h068, 32'h1, "detach event");
    wait_irq(1'b0);
    $display("power and attach done");
  endtask
  // Power off clears the port drives, not test mode; controller reset restores defaults but keeps the mask
  task automatic t_hcrst();
    wr(12'h064, 32'h000511c0);
    rd(12'h064, 32'h000511c2, "drives on");
    `CHK("drv", 3'h7, drv)
    wr(12'h064, 32'h00050000);
    rd(12'h064, 32'h00050000, "power off");
    `CHK("drv", 3'h0, drv)
    @(posedge pclk) hc_reset <= 1'b1;
    @(posedge pclk) hc_reset <= 1'b0;
    rd(12'h064, 32'h00002000, "hc port");
    rd(12'h060, 32'h0, "hc setup");
    rd(12'h06c, 32'h1, "hc mask");
    $display("controller reset done");
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_refuse();
    t_setup();
    t_power();
    t_hcrst();
    end_of_test();
  end
endmodule
